// ===== rtl/nvsram_host_ctrl.v
`timescale 1ns/1ns
`include "nvsram_host_defs.vh"
module nvsram_host_ctrl #(
  parameter PWRUP_CYC  = `CYC_PWRUP,
  parameter STORE_CYC  = `CYC_STORE,
  parameter RECALL_CYC = `CYC_RECALL
) (
  input  wire                 clock_i,
  input  wire                 rst_n_i,
  input  wire                 req_valid_i,
  input  wire [1:0]           req_op_i,
  input  wire [`ADDR_W-1:0]   req_addr_i,
  input  wire [`DATA_W-1:0]   req_wdata_i,
  output wire                 req_ready_o,
  output reg                  rsp_valid_o,
  output reg  [`DATA_W-1:0]   rsp_rdata_o,
  output reg                  busy_o,
  output reg                  write_pending_o,
  output reg  [`ADDR_W-1:0]   mem_addr_o,
  output reg                  mem_chip_sel_n_o,
  output reg                  mem_write_n_o,
  output reg                  mem_out_en_n_o,
  output reg  [`DATA_W-1:0]   mem_dq_o,
  output reg                  mem_dq_oe_o,
  input  wire [`DATA_W-1:0]   mem_dq_i,
  output reg                  store_busy_n_o,
  output reg                  store_busy_n_oe_o,
  input  wire                 store_busy_n_i
);
  // req_op: 0 read, 1 write, 2 software store, 3 software recall (hardware store when addr bit 14 set)
  localparam OP_RD  = 2'h0;
  localparam OP_WR  = 2'h1;
  localparam OP_STO = 2'h2;
  localparam OP_REC = 2'h3;
  localparam S_PWRUP = 6'b000001;
  localparam S_IDLE  = 6'b000010;
  localparam S_ACC   = 6'b000100;
  localparam S_NVW   = 6'b001000;
  localparam S_HSB   = 6'b010000;
  localparam S_REL   = 6'b100000;
  localparam [`CNT_W-1:0] ACC_CYC  = `CYC_ACCESS;
  localparam [`CNT_W-1:0] SEQP_CYC = `CYC_SEQ_PULSE;
  localparam [`CNT_W-1:0] HSBP_CYC = `CYC_HSB_PULSE;
  localparam [`CNT_W-1:0] PWR_C    = PWRUP_CYC;
  localparam [`CNT_W-1:0] STO_C    = STORE_CYC;
  localparam [`CNT_W-1:0] REC_C    = RECALL_CYC;
  localparam [`CNT_W-1:0] CNT_ONE  = 24'h000001;

  reg [5:0]          state_ff;
  reg [`CNT_W-1:0]   cnt_ff;
  reg [2:0]          seq_ff;
  reg                is_rd_ff;
  reg                hsb_meta_ff;
  reg                hsb_sync_ff;
  reg [`DATA_W-1:0]  dq_meta_ff;
  reg [`DATA_W-1:0]  dq_sync_ff;
  reg [`ADDR_W-1:0]  seq_addr;

  // external data pins and store_busy_n come from another domain
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hsb_meta_ff <= 1'b1;
      hsb_sync_ff <= 1'b1;
      dq_meta_ff  <= 8'h00;
      dq_sync_ff  <= 8'h00;
    end else begin
      hsb_meta_ff <= store_busy_n_i;
      hsb_sync_ff <= hsb_meta_ff;
      dq_meta_ff  <= mem_dq_i;
      dq_sync_ff  <= dq_meta_ff;
    end
  end

  always @* begin
    case (seq_ff)
      3'h0:    seq_addr = `SEQ_A1;
      3'h1:    seq_addr = `SEQ_A2;
      3'h2:    seq_addr = `SEQ_A3;
      3'h3:    seq_addr = `SEQ_A4;
      3'h4:    seq_addr = `SEQ_A5;
      default: seq_addr = (req_op_i == OP_STO) ? `SEQ_STORE : `SEQ_RECALL;
    endcase
  end

  // accept only when idle and device not busy; accepts stall otherwise
  // busy must drop first, so ready never overlaps a stale busy
  assign req_ready_o = (state_ff == S_IDLE) && hsb_sync_ff && !busy_o;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff          <= S_PWRUP;
      cnt_ff            <= 24'h000000;
      seq_ff            <= 3'h0;
      is_rd_ff          <= 1'b0;
      rsp_valid_o       <= 1'b0;
      rsp_rdata_o       <= 8'h00;
      busy_o            <= 1'b1;
      write_pending_o   <= 1'b0;
      mem_addr_o        <= 15'h0000;
      mem_chip_sel_n_o  <= 1'b1;
      mem_write_n_o     <= 1'b1;
      mem_out_en_n_o    <= 1'b1;
      mem_dq_o          <= 8'h00;
      mem_dq_oe_o       <= 1'b0;
      store_busy_n_o    <= 1'b0;
      store_busy_n_oe_o <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      case (state_ff)
        S_PWRUP: begin
          // wait out the device's own power-up recall
          if (cnt_ff >= PWR_C - CNT_ONE) begin
            state_ff <= S_IDLE;
            busy_o   <= 1'b0;
            cnt_ff   <= 24'h000000;
          end else begin
            cnt_ff <= cnt_ff + CNT_ONE;
          end
        end
        S_IDLE: begin
          if (!hsb_sync_ff) begin
            // device busy (auto or pin store): hold off
            busy_o <= 1'b1;
          end else begin
            busy_o <= 1'b0;
            if (req_valid_i) begin
              cnt_ff <= 24'h000000;
              if (req_op_i == OP_RD || req_op_i == OP_WR) begin
                seq_ff           <= 3'h0;
                mem_addr_o       <= req_addr_i;
                is_rd_ff         <= (req_op_i == OP_RD);
                mem_chip_sel_n_o <= 1'b0;
                mem_write_n_o    <= (req_op_i != OP_WR);
                mem_out_en_n_o   <= (req_op_i == OP_WR);
                mem_dq_o         <= req_wdata_i;
                mem_dq_oe_o      <= (req_op_i == OP_WR);
                state_ff         <= S_ACC;
              end else begin
                // one read pulse of the sequence per request, output drive left high
                mem_addr_o       <= seq_addr;
                mem_chip_sel_n_o <= 1'b0;
                mem_write_n_o    <= 1'b1;
                mem_out_en_n_o   <= 1'b1;
                state_ff         <= S_NVW;
              end
            end
          end
        end
        S_ACC: begin
          // address held across the whole strobe
          if (cnt_ff >= ACC_CYC) begin
            mem_chip_sel_n_o <= 1'b1;
            mem_write_n_o    <= 1'b1;
            mem_out_en_n_o   <= 1'b1;
            mem_dq_oe_o      <= 1'b0;
            rsp_valid_o      <= 1'b1;
            rsp_rdata_o      <= is_rd_ff ? dq_sync_ff : 8'h00;
            if (!is_rd_ff)
              write_pending_o <= 1'b1;
            state_ff <= S_IDLE;
          end else begin
            cnt_ff <= cnt_ff + CNT_ONE;
          end
        end
        S_NVW: begin
          // pulse need only meet the minimum width, not access time
          if (cnt_ff >= SEQP_CYC) begin
            mem_chip_sel_n_o <= 1'b1;
            cnt_ff           <= 24'h000000;
            if (seq_ff == 3'h5) begin
              seq_ff <= 3'h0;
              busy_o <= 1'b1;
              if (req_op_i == OP_STO)
                write_pending_o <= 1'b0;
              state_ff <= S_REL;
              is_rd_ff <= (req_op_i == OP_STO);
            end else begin
              seq_ff   <= seq_ff + 3'h1;
              state_ff <= S_IDLE;
            end
          end else begin
            cnt_ff <= cnt_ff + CNT_ONE;
          end
        end
        S_HSB: begin
          // drive store_busy_n low long enough to request a store
          if (cnt_ff >= HSBP_CYC) begin
            store_busy_n_oe_o <= 1'b0;
            cnt_ff            <= 24'h000000;
            write_pending_o   <= 1'b0;
            state_ff          <= S_REL;
          end else begin
            cnt_ff <= cnt_ff + CNT_ONE;
          end
        end
        S_REL: begin
          // wait nonvolatile cycle time and store_busy_n release
          if (cnt_ff >= (is_rd_ff ? STO_C : REC_C) && hsb_sync_ff) begin
            busy_o   <= 1'b0;
            cnt_ff   <= 24'h000000;
            state_ff <= S_IDLE;
          end else if (cnt_ff < STO_C) begin
            cnt_ff <= cnt_ff + CNT_ONE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
      // hardware store request: software ops 3 with addr msb set reuse pin path
      if (req_ready_o && req_valid_i && req_op_i == OP_REC && req_addr_i[14]) begin
        store_busy_n_oe_o <= 1'b1;
        store_busy_n_o    <= 1'b0;
        busy_o            <= 1'b1;
        is_rd_ff          <= 1'b1;
        mem_chip_sel_n_o  <= 1'b1;
        cnt_ff            <= 24'h000000;
        state_ff          <= S_HSB;
      end
    end
  end
endmodule

// ===== rtl/nvsram_host_defs.vh
`ifndef NVSRAM_HOST_DEFS_VH
`define NVSRAM_HOST_DEFS_VH
`define ADDR_W        15
`define DATA_W        8
`define SEQ_A1        15'h0E38
`define SEQ_A2        15'h31C7
`define SEQ_A3        15'h03E0
`define SEQ_A4        15'h3C1F
`define SEQ_A5        15'h303F
`define SEQ_STORE     15'h0FC0
`define SEQ_RECALL    15'h0C63
`define CLK_PERIOD_NS 4
`define T_SEQ_PULSE_NS  30
`define T_ACCESS_NS     45
`define T_HSB_PULSE_NS  20
`define T_STORE_NS      10000000
`define T_RECALL_NS     20000
`define T_PWRUP_NS      650000
`define CYC_SEQ_PULSE ((`T_SEQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_ACCESS    ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_HSB_PULSE ((`T_HSB_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_STORE     ((`T_STORE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_RECALL    ((`T_RECALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_PWRUP     ((`T_PWRUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W         24
`endif

// ===== test/nvsram_dev_model.sv
`timescale 1ns/1ns
module nvsram_dev_model #(parameter ST = 50, parameter RC = 20) (
  input  wire        clock_i,
  input  wire [14:0] a_i,
  input  wire        cs_n_i,
  input  wire        we_n_i,
  input  wire        oe_n_i,
  input  wire [7:0]  d_i,
  input  wire        hsb_i,
  output reg  [7:0]  q_o,
  output reg         hsb_drv_o
);
  reg [7:0] m [0:32767];
  reg [14:0] la;
  reg [7:0] ld, last = 8'h00;
  reg lwe = 1, pcs = 1, wflag = 0;
  int idx = 0, cnt = RC, n_store = 0, n_recall = 0;
  initial hsb_drv_o = 0;
  function [14:0] sa(input int i);
    case (i) 0: sa = 15'h0E38; 1: sa = 15'h31C7; 2: sa = 15'h03E0; 3: sa = 15'h3C1F; default: sa = 15'h303F; endcase
  endfunction
  // released bus shows the inverse, not a held value
  always @* q_o = (!cs_n_i && !oe_n_i && we_n_i && hsb_i && cnt == 0) ? m[a_i] : ~last;
  always @(posedge clock_i) begin
    pcs <= cs_n_i;
    if (!cs_n_i) begin
      la <= a_i;
      lwe <= we_n_i;
      ld <= d_i;
    end
    if (!cs_n_i && !oe_n_i && we_n_i) last <= m[a_i];
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) hsb_drv_o <= 0;
    end else if (!hsb_i && !hsb_drv_o) begin
      idx <= 0;
      if (wflag) begin
        n_store <= n_store + 1; wflag <= 0; cnt <= ST; hsb_drv_o <= 1;
      end
    end else if (cs_n_i && !pcs) begin
      if (!lwe) begin m[la] <= ld; wflag <= 1; idx <= 0; end
      else if (idx == 5 && la == 15'h0FC0) begin
        n_store <= n_store + 1; wflag <= 0; cnt <= ST; hsb_drv_o <= 1; idx <= 0;
      end else if (idx == 5 && la == 15'h0C63) begin n_recall <= n_recall + 1; cnt <= RC; idx <= 0; end
      else idx <= (idx < 5 && la == sa(idx)) ? idx + 1 : (la == sa(0));
    end
  end
endmodule

// ===== test/nvsram_host_ctrl_assertions.sv
`timescale 1ns/1ns
`include "nvsram_host_defs.vh"
module nvsram_host_ctrl_assertions (
  input wire               clock_i,
  input wire               rst_n_i,
  input wire               req_ready_o,
  input wire               rsp_valid_o,
  input wire               busy_o,
  input wire [`ADDR_W-1:0] mem_addr_o,
  input wire               mem_chip_sel_n_o,
  input wire               mem_write_n_o,
  input wire               mem_out_en_n_o,
  input wire               mem_dq_oe_o,
  input wire               store_busy_n_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_dq; !mem_chip_sel_n_o && !mem_out_en_n_o |-> !mem_dq_oe_o; endproperty
  a_rd_dq: assert property (p_rd_dq) else $error("dq driven during read");
  property p_wr_oe; !mem_write_n_o |-> mem_out_en_n_o; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("output drive low in write");
  property p_wr_dq; !mem_chip_sel_n_o && !mem_write_n_o |-> mem_dq_oe_o; endproperty
  a_wr_dq: assert property (p_wr_dq) else $error("write without data drive");
  property p_wr_addr; !mem_chip_sel_n_o && !mem_write_n_o ##1 !mem_write_n_o |-> $stable(mem_addr_o); endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("address moved in write");
  property p_wr_rsp; $fell(mem_chip_sel_n_o) && !mem_write_n_o |-> ##[12:14] rsp_valid_o; endproperty
  a_wr_rsp: assert property (p_wr_rsp) else $error("write answer late");
  property p_busy; busy_o |-> !req_ready_o; endproperty
  a_busy: assert property (p_busy) else $error("ready while busy");
  property p_pin_low; !store_busy_n_i |-> ##2 !req_ready_o; endproperty
  a_pin_low: assert property (p_pin_low) else $error("ready with store line low");
  property p_pwrup; $rose(rst_n_i) |-> busy_o [*8]; endproperty
  a_pwrup: assert property (p_pwrup) else $error("no power-up wait");
endmodule
bind nvsram_host_ctrl nvsram_host_ctrl_assertions chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
  .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .busy_o(busy_o), .mem_addr_o(mem_addr_o),
  .mem_chip_sel_n_o(mem_chip_sel_n_o), .mem_write_n_o(mem_write_n_o), .mem_out_en_n_o(mem_out_en_n_o),
  .mem_dq_oe_o(mem_dq_oe_o), .store_busy_n_i(store_busy_n_i));

// ===== test/nvsram_host_ctrl_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module nvsram_store_recall_control_tb;
  reg clock_i = 0, rst_n_i = 0, req_valid_i = 0;
  reg [1:0] req_op_i = 0;
  reg [14:0] req_addr_i = 0, a;
  reg [7:0] req_wdata_i = 0, d, dev_q;
  reg [7:0] shadow [0:32767];
  wire req_ready_o, rsp_valid_o, busy_o, write_pending_o, cs_n, we_n, oe_n, dq_oe, sb_o, sb_oe, drv;
  wire [7:0] rsp_rdata_o, dq_o;
  wire [14:0] ma;
  wire store_busy_n = !(sb_oe || drv);
  int n_mismatch = 0, tests_run = 0, s0, r0, i, k;
  reg [31:0] seed = 24699;
  always #2 clock_i = ~clock_i;
  nvsram_host_ctrl #(.PWRUP_CYC(20), .STORE_CYC(50), .RECALL_CYC(20)) uut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .busy_o(busy_o),
    .write_pending_o(write_pending_o), .mem_addr_o(ma), .mem_chip_sel_n_o(cs_n), .mem_write_n_o(we_n),
    .mem_out_en_n_o(oe_n), .mem_dq_o(dq_o), .mem_dq_oe_o(dq_oe), .mem_dq_i(dq_oe ? dq_o : dev_q),
    .store_busy_n_o(sb_o), .store_busy_n_oe_o(sb_oe), .store_busy_n_i(store_busy_n));
  nvsram_dev_model #(.ST(50), .RC(20)) dev (.clock_i(clock_i), .a_i(ma), .cs_n_i(cs_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .d_i(dq_o), .hsb_i(store_busy_n), .q_o(dev_q), .hsb_drv_o(drv));
  function [31:0] xs();
    seed = seed ^ (seed << 13); seed = seed ^ (seed >> 17); seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task req(input [1:0] o, input [14:0] ad, input [7:0] wd);
    k = 0;
    req_op_i = o; req_addr_i = ad; req_wdata_i = wd; req_valid_i = 1;
    while (req_ready_o !== 1'b1 && k < 2000) begin @(posedge clock_i); #1; k++; end
    if (k >= 2000) n_mismatch++;
    @(posedge clock_i); #1 req_valid_i = 0;
  endtask
  task rsp();
    k = 0;
    while (rsp_valid_o !== 1'b1 && k < 50) begin @(posedge clock_i); #1; k++; end
    if (k >= 50) n_mismatch++;
  endtask
  task idle();
    k = 0;
    repeat (3) @(posedge clock_i);
    #1 while (req_ready_o !== 1'b1 && k < 2000) begin @(posedge clock_i); #1; k++; end
    if (k >= 2000) n_mismatch++;
  endtask
  task wr(input [14:0] ad, input [7:0] wd); req(1, ad, wd); rsp(); shadow[ad] = wd; endtask
  task rd(input [14:0] ad); req(0, ad, 0); rsp(); `CHK("rdata", shadow[ad], rsp_rdata_o) endtask
  task seq(input [1:0] o); repeat (6) req(o, 0, 0); idle(); endtask
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin #100000; n_mismatch++; tally_and_finish(); end
  initial begin
    repeat (2) @(posedge clock_i);
    #1 rst_n_i = 1;
    wr(15'h0000, 8'hA5); wr(15'h7FFF, 8'h5A); rd(15'h0000); rd(15'h7FFF);
    for (i = 0; i < 12; i++) begin a = xs(); d = xs(); wr(a, d); rd(a); end
    `CHK("pending", 1'b1, write_pending_o)
    $display("test 1 done");
    s0 = dev.n_store;
    repeat (3) req(2, 0, 0);
    rd(a); idle(); `CHK("abort", s0, dev.n_store)
    seq(2); `CHK("sw store", s0 + 1, dev.n_store)
    `CHK("pending", 1'b0, write_pending_o)
    `CHK("busy", 1'b0, busy_o)
    rd(a); $display("test 2 done");
    req(3, 15'h4000, 0); idle(); `CHK("pin no wr", s0 + 1, dev.n_store)
    wr(15'h0123, 8'h3C); req(3, 15'h4000, 0); idle(); `CHK("pin store", s0 + 2, dev.n_store)
    $display("test 3 done");
    r0 = dev.n_recall; seq(3); `CHK("recall", r0 + 1, dev.n_recall)
    rd(15'h0123); $display("test 4 done");
    tally_and_finish();
  end
endmodule
